// ==== core/lsd_pkg.sv ====
// Package of constants for the LED sink driver serial control block
package lsd_pkg;
    localparam int CHANNELS       = 16;                  // Number of sink channels
    localparam int TRIM_WIDTH     = 7;                   // Bits per current trim word
    localparam int TRIM_MAX       = 127;                 // Full-scale trim value
    localparam int TRIM_BITS      = CHANNELS * TRIM_WIDTH; // Trim packet length, 112
    localparam int ONOFF_BITS     = CHANNELS;            // On/off packet length, 16
    localparam int CLK_PERIOD_NS  = 100;                 // Core clock period in ns
    localparam int STAGGER_NS     = 20;                  // Per-channel switching delay in ns
    localparam int OPEN_SAMPLE_NS = 1000;                // Open-LED sample delay after turn-on in ns
    // Longest time rounds down, at least one cycle
    localparam int STAGGER_CYC_RAW = STAGGER_NS / CLK_PERIOD_NS;
    localparam int STAGGER_CYC     = (STAGGER_CYC_RAW < 1) ? 1 : STAGGER_CYC_RAW;
    // Least time rounds up
    localparam int OPEN_SAMPLE_CYC = (OPEN_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_WIDTH       = 8;                  // Width of per-channel delay counters
    localparam logic [CHANNELS-1:0]  ONOFF_RESET = 16'h0000; // On/off register after reset
    localparam logic [TRIM_BITS-1:0] TRIM_RESET  = '0;       // Trim register after reset
    localparam int ST_THERMAL   = 0;                     // Interrupt status bit: thermal flag
    localparam int ST_OPEN      = 1;                     // Interrupt status bit: open-LED flag
    localparam int ST_LATCH     = 2;                     // Interrupt status bit: latch done
    localparam int ST_WIDTH     = 3;                     // Width of status and mask
    localparam logic [ST_WIDTH-1:0] MASK_RESET = 3'h0;   // Mask after reset, all masked
    localparam logic [1:0] ADDR_STATUS = 2'h0;           // Interrupt status, write one to clear
    localparam logic [1:0] ADDR_MASK   = 2'h1;           // Interrupt mask
    localparam logic [1:0] ADDR_ONOFF  = 2'h2;           // On/off register, read only
    localparam logic [1:0] ADDR_OPEN   = 2'h3;           // Open-LED flags, read only
endpackage

// ==== core/lsd_serial_ctrl.sv ====
// Serial control logic of the sixteen channel LED sink driver
//
// Notes on behaviour
// - Hold seven-bit current trim per channel.
// - Trim packet is 112 bits, MSB first.
// - Mode high selects 112-bit trim path.
// - Latch rise in trim mode loads trim.
// - Disable high forces every channel off.
// - On/off packet 16 bits, bit n channel n.
// - Mode low, latch rise loads on/off register.
// - Mode low, latch fall reloads shifter with open status.
// - Channel n switches n stagger steps later.
// - Delayed channels complete on and off anyway.
// - Shift clock rise shifts serial input in.
// - Bits leaving shifter appear on serial out.
// - Error output open drain, low on flags.
// - Disable high masks open-LED from error.
// - Over-temperature sets thermal flag, error low.
// - Open flag sampled 1 us after turn-on.
`timescale 1ns/100ps
module lsd_serial_ctrl
    import lsd_pkg::*;
#(
    parameter int CH   = lsd_pkg::CHANNELS,
    parameter int TW   = lsd_pkg::TRIM_WIDTH
)(
    input  wire logic                     core_clk_i,      // Core clock, 10 MHz
    input  wire logic                     nrst_i,          // Asynchronous reset, active low
    input  wire logic                     clk_en_i,        // Clock enable, freezes all state when low
    input  wire logic                     shift_clk_i,     // Serial shift clock pin
    input  wire logic                     serial_in_i,     // Serial data pin
    input  wire logic                     latch_strobe_i,  // Latch strobe pin
    input  wire logic                     mode_sel_i,      // Mode select, high selects trim path
    input  wire logic                     out_disable_i,   // Output disable pin, high blanks all
    input  wire logic                     over_temp_i,     // Over-temperature indication
    input  wire logic [CH-1:0]            out_low_i,       // Channel output below open threshold
    input  wire logic [1:0]               addr_i,          // Register address
    input  wire logic [31:0]              wdata_i,         // Register write data
    input  wire logic                     wr_i,            // Register write strobe
    input  wire logic                     rd_i,            // Register read strobe
    output logic      [31:0]              rdata_o,         // Register read data, cycle after read
    output logic                          irq_o,           // Level interrupt
    output logic                          serial_out_o,    // Serial data out
    output logic      [CH-1:0]            sink_en_o,       // Per-channel sink enable after stagger
    output logic      [CH*TW-1:0]         current_trim_o,  // Trim words, channel 0 in low bits
    output logic                          error_out_n_o,   // Open-drain error output level, always 0
    output logic                          error_out_n_oe_o // Error pin drive enable, high pulls low
);
    import lsd_pkg::*;

    localparam int TB = CH * TW;          // Trim shifter length



    // Pins arrive asynchronously
    //
    // Pin synchronisers: three stages, a change counts once stages two and three agree
    logic [2:0]     sclk_sync_reg;        // Shift clock synchroniser
    logic [2:0]     sin_sync_reg;         // Serial data synchroniser
    logic [2:0]     lat_sync_reg;         // Latch synchroniser
    logic [2:0]     mode_sync_reg;        // Mode synchroniser
    logic [2:0]     dis_sync_reg;         // Disable synchroniser
    logic [2:0]     temp_sync_reg;        // Over-temperature synchroniser
    logic           sclk_st_reg;          // Accepted shift clock level
    logic           lat_st_reg;           // Accepted latch level
    logic           mode_st_reg;          // Accepted mode level
    logic           dis_st_reg;           // Accepted disable level
    logic           temp_st_reg;          // Accepted over-temperature level
    logic [CH-1:0]  low_s1_reg;           // Output-voltage comparators, stage 1
    logic [CH-1:0]  low_s2_reg;           // Stage 2
    logic [CH-1:0]  low_s3_reg;           // Stage 3



    // Holds the last level while stages differ
    //
    // Agreement of stages two and three of a synchroniser
    function automatic logic agreed(input logic [2:0] s, input logic prev);
        agreed = (s[1] == s[2]) ? s[2] : prev;
    endfunction



    // Stage one may go metastable
    //
    // Synchroniser shift for all pins
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sclk_sync_reg <= 3'h0;
            sin_sync_reg  <= 3'h0;
            lat_sync_reg  <= 3'h0;
            mode_sync_reg <= 3'h0;
            dis_sync_reg  <= 3'h7;     // Blanked until the pin is seen
            temp_sync_reg <= 3'h0;
            low_s1_reg    <= '0;
            low_s2_reg    <= '0;
            low_s3_reg    <= '0;
        end
        else if (clk_en_i)
        begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], shift_clk_i};
            sin_sync_reg  <= {sin_sync_reg[1:0], serial_in_i};
            lat_sync_reg  <= {lat_sync_reg[1:0], latch_strobe_i};
            mode_sync_reg <= {mode_sync_reg[1:0], mode_sel_i};
            dis_sync_reg  <= {dis_sync_reg[1:0], out_disable_i};
            temp_sync_reg <= {temp_sync_reg[1:0], over_temp_i};
            low_s1_reg    <= out_low_i;
            low_s2_reg    <= low_s1_reg;
            low_s3_reg    <= low_s2_reg;
        end
    end



    // Edges come from these levels
    //
    // Accepted levels, updated only when stages two and three agree
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sclk_st_reg <= 1'b0;
            lat_st_reg  <= 1'b0;
            mode_st_reg <= 1'b0;
            dis_st_reg  <= 1'b1;
            temp_st_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
            sclk_st_reg <= agreed(sclk_sync_reg, sclk_st_reg);
            lat_st_reg  <= agreed(lat_sync_reg, lat_st_reg);
            mode_st_reg <= agreed(mode_sync_reg, mode_st_reg);
            dis_st_reg  <= agreed(dis_sync_reg, dis_st_reg);
            temp_st_reg <= agreed(temp_sync_reg, temp_st_reg);
        end
    end



    // Events last one cycle each
    //
    // Edge events of the accepted levels
    logic sclk_rise;                      // Shift clock rising edge
    logic lat_rise;                       // Latch rising edge
    logic lat_fall;                       // Latch falling edge
    assign sclk_rise = clk_en_i && !sclk_st_reg && agreed(sclk_sync_reg, sclk_st_reg);
    assign lat_rise  = clk_en_i && !lat_st_reg && agreed(lat_sync_reg, lat_st_reg);
    assign lat_fall  = clk_en_i && lat_st_reg && !agreed(lat_sync_reg, lat_st_reg);



    // Both shifters kept at all times
    //
    // Shift registers and latched data
    logic [TB-1:0]  trim_shift_reg;       // 112-bit trim input shifter
    logic [CH-1:0]  onoff_shift_reg;      // 16-bit on/off input shifter
    logic [TB-1:0]  trim_reg;             // Current trim register
    logic [CH-1:0]  onoff_reg;            // On/off register
    logic [CH-1:0]  open_flag_reg;        // Per-channel open-LED flags



    // Moves only in trim mode
    //
    // Trim path shifter, MSB first so the first bit ends at the top
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            trim_shift_reg <= '0;
        else if (sclk_rise && mode_st_reg)
            trim_shift_reg <= {trim_shift_reg[TB-2:0], sin_sync_reg[2]};
    end



    // Reload wins over a shift
    //
    // On/off shifter, reloaded with open status on the latch fall
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            onoff_shift_reg <= '0;
        else if (lat_fall && !mode_st_reg)
            onoff_shift_reg <= open_flag_reg;
        else if (sclk_rise && !mode_st_reg)
            onoff_shift_reg <= {onoff_shift_reg[CH-2:0], sin_sync_reg[2]};
    end



    // Mode picks the destination
    //
    // Latching on the strobe rise into the register chosen by mode
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            trim_reg  <= TRIM_RESET;
            onoff_reg <= ONOFF_RESET;
        end
        else if (lat_rise)
        begin
            if (mode_st_reg)
                trim_reg <= trim_shift_reg;
            else
                onoff_reg <= onoff_shift_reg;
        end
    end



    // One cycle behind the shifter
    //
    // Serial output from the shifter top of the selected path; the chain needs no extra stage
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            serial_out_o <= 1'b0;
        else if (clk_en_i)
            serial_out_o <= mode_st_reg ? trim_shift_reg[TB-1] : onoff_shift_reg[CH-1];
    end



    // Analogue trim sits outside
    //
    // Trim words out; word for channel 15 was shifted first so it sits at the top
    assign current_trim_o = trim_reg;



    // Stagger limits inrush current
    //
    // Per-channel stagger and open-LED sampling
    logic [CH-1:0]  demand;               // Requested sink state before stagger
    logic [CH-1:0]  sink_reg;             // Staggered sink state
    logic           open_any;             // Any open-LED flag set
    assign demand = onoff_reg & {CH{!dis_st_reg}};

    generate
        for (genvar n = 0; n < CH; n++)
        begin : g_ch
            logic [CNT_WIDTH-1:0] dly_reg;      // Stagger countdown
            logic                 target_reg;   // State being delayed toward
            logic [CNT_WIDTH-1:0] smp_reg;      // Time since turn-on
            // A pending change runs to its end even if demand flips back, so
            // an on that started late still gives the full lit time
            always_ff @(posedge core_clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    dly_reg    <= '0;
                    target_reg <= 1'b0;
                    sink_reg[n] <= 1'b0;
                end
                else if (clk_en_i)
                begin
                    if (dly_reg != '0)
                    begin
                        dly_reg <= dly_reg - 1'b1;
                        if (dly_reg == CNT_WIDTH'(1))
                            sink_reg[n] <= target_reg;
                    end
                    else if (demand[n] != sink_reg[n])
                    begin
                        if (n == 0)
                            sink_reg[n] <= demand[n];
                        else
                        begin
                            target_reg <= demand[n];
                            dly_reg    <= CNT_WIDTH'(n * STAGGER_CYC);
                        end
                    end
                end
            end


            // Flag kept until the next sample
            //
            // Count time on, sample the comparator once the settle time has passed
            always_ff @(posedge core_clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    smp_reg          <= '0;
                    open_flag_reg[n] <= 1'b0;
                end
                else if (clk_en_i)
                begin
                    if (!sink_reg[n])
                        smp_reg <= '0;
                    else if (smp_reg != CNT_WIDTH'(OPEN_SAMPLE_CYC))
                        smp_reg <= smp_reg + 1'b1;
                    if (!dis_st_reg && sink_reg[n] && smp_reg == CNT_WIDTH'(OPEN_SAMPLE_CYC - 1))
                        open_flag_reg[n] <= (low_s2_reg[n] == low_s3_reg[n]) ? low_s3_reg[n] : open_flag_reg[n];
                end
            end
        end
    endgenerate

    assign sink_en_o = sink_reg;
    assign open_any  = |open_flag_reg;



    // Pin is shared by wired-OR
    //
    // Error pin: pull low on thermal, or on open-LED while not blanked
    logic thermal_flag;                   // Thermal flag
    assign thermal_flag = temp_st_reg;
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            error_out_n_oe_o <= 1'b0;
        else if (clk_en_i)
            error_out_n_oe_o <= thermal_flag || (open_any && !dis_st_reg);
    end
    assign error_out_n_o = 1'b0;          // Open drain only ever drives low



    // Events gathered into three bits
    //
    // Interrupt status and mask
    logic [ST_WIDTH-1:0] status_reg;      // Sticky event bits
    logic [ST_WIDTH-1:0] mask_reg;        // One enables the bit onto irq
    logic [ST_WIDTH-1:0] events;          // Events this cycle
    assign events = {lat_rise, open_any, thermal_flag};



    // Clear takes a write of one
    //
    // Set wins over write-one-to-clear so no event is lost
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            status_reg <= '0;
        else if (clk_en_i)
        begin
            if (wr_i && addr_i == ADDR_STATUS)
                status_reg <= (status_reg & ~wdata_i[ST_WIDTH-1:0]) | events;
            else
                status_reg <= status_reg | events;
        end
    end



    // Mask of zero hides all
    //
    // Mask register write
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            mask_reg <= MASK_RESET;
        else if (clk_en_i && wr_i && addr_i == ADDR_MASK)
            mask_reg <= wdata_i[ST_WIDTH-1:0];
    end

    assign irq_o = |(status_reg & mask_reg);



    // Reads never stall the bus
    //
    // Read data, valid the cycle after the strobe only
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rdata_o <= '0;
        else if (clk_en_i)
        begin
            rdata_o <= '0;
            if (rd_i)
            begin
                case (addr_i)
                    ADDR_STATUS: rdata_o <= {{(32-ST_WIDTH){1'b0}}, status_reg};
                    ADDR_MASK:   rdata_o <= {{(32-ST_WIDTH){1'b0}}, mask_reg};
                    ADDR_ONOFF:  rdata_o <= {{(32-CH){1'b0}}, onoff_reg};
                    ADDR_OPEN:   rdata_o <= {{(32-CH){1'b0}}, open_flag_reg};
                    default:     rdata_o <= '0;
                endcase
            end
        end
    end
endmodule

// ==== tb/lsd_serial_ctrl_asserts.sv ====
// Port-level checker of the LED sink driver serial control
`timescale 1ns/100ps
module lsd_serial_ctrl_asserts
    import lsd_pkg::*;
#(
    parameter int CH = lsd_pkg::CHANNELS,
    parameter int TW = lsd_pkg::TRIM_WIDTH
)(
    input wire logic                core_clk_i,       // Core clock
    input wire logic                nrst_i,           // Reset, active low
    input wire logic                clk_en_i,         // Clock enable
    input wire logic                mode_sel_i,       // Mode select pin
    input wire logic                out_disable_i,    // Blanking pin
    input wire logic                over_temp_i,      // Over-temperature level
    input wire logic [1:0]          addr_i,           // Register address
    input wire logic [31:0]         wdata_i,          // Register write data
    input wire logic                wr_i,             // Write strobe
    input wire logic                rd_i,             // Read strobe
    input wire logic [31:0]         rdata_o,          // Read data
    input wire logic                irq_o,            // Interrupt level
    input wire logic [CH-1:0]       sink_en_o,        // Channel enables
    input wire logic [CH*TW-1:0]    current_trim_o,   // Trim words
    input wire logic                error_out_n_o,    // Error pin level
    input wire logic                error_out_n_oe_o  // Error pin drive
);
    logic [ST_WIDTH-1:0] mask_reg;      // Mirror of the mask written over the bus
    logic [5:0]          blank_cnt_reg; // Cycles of blanking held, saturating

    // Mirror the mask so read data can be judged without the body
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            mask_reg <= MASK_RESET;
        else if (clk_en_i && wr_i && addr_i == ADDR_MASK)
            mask_reg <= wdata_i[ST_WIDTH-1:0];
    end

    // Delayed channels may still finish after blanking, so wait well past the stagger
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            blank_cnt_reg <= 6'h00;
        else if (!out_disable_i)
            blank_cnt_reg <= 6'h00;
        else if (blank_cnt_reg != 6'h3f)
            blank_cnt_reg <= blank_cnt_reg + 6'h01;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    // Steps: hot for long enough to pass the synchronisers
    sequence hot_seq;
        over_temp_i [*6];
    endsequence
    // Steps: cool and blanked, so open flags are hidden
    sequence cool_blank_seq;
        (!over_temp_i && out_disable_i) [*6];
    endsequence

    AST_ERR_THERMAL: assert property (hot_seq |-> error_out_n_oe_o)
        else $error("error pin not driven while hot");
    AST_ERR_MASKED: assert property (cool_blank_seq |-> !error_out_n_oe_o)
        else $error("error pin driven while blanked and cool");
    AST_ERR_LEVEL: assert property (error_out_n_o == 1'b0)
        else $error("error pin level not low");
    AST_BLANK_OFF: assert property (blank_cnt_reg > 6'd30 |-> sink_en_o == '0)
        else $error("channel on while blanked");
    AST_TRIM_HOLD: assert property (!mode_sel_i [*6] |-> $stable(current_trim_o))
        else $error("trim changed in on/off mode");
    AST_READ_IDLE: assert property (clk_en_i && !rd_i |=> rdata_o == 32'h0)
        else $error("read data not zero outside read");
    AST_MASK_READ: assert property (clk_en_i && rd_i && addr_i == ADDR_MASK |=> rdata_o == 32'(mask_reg))
        else $error("mask read data wrong");
    AST_IRQ_MASKED: assert property (mask_reg == '0 |-> !irq_o)
        else $error("interrupt raised with all masked");
endmodule

// ==== tb/lsd_host_model.sv ====
// Host model that drives the serial link of the LED sink driver
`timescale 1ns/100ps
module lsd_host_model
    import lsd_pkg::*;
(
    input  wire logic core_clk_i,     // Core clock, paces the link
    input  wire logic serial_out_i,   // Serial data from the device
    output logic      shift_clk_o,    // Shift clock, still outside frames
    output logic      serial_in_o,    // Serial data to the device
    output logic      latch_strobe_o, // Latch strobe
    output logic      mode_sel_o      // Mode select
);
    // Quiet link at time zero
    initial
    begin
        shift_clk_o = 1'b0;
        serial_in_o = 1'b0;
        latch_strobe_o = 1'b0;
        mode_sel_o = 1'b0;
    end

    // Four core cycles per phase gives the 800 ns link period
    task automatic phase();
        repeat (4) @(posedge core_clk_i);
    endtask

    // One frame: mode, bits MSB first, latch rise then fall; rx collects serial out
    task automatic send(input logic mode, input logic [TRIM_BITS-1:0] data, input int nbits,
                        output logic [TRIM_BITS-1:0] rx);
        rx = '0;
        mode_sel_o <= mode;
        phase();
        for (int i = nbits - 1; i >= 0; i--)
        begin
            serial_in_o <= data[i];
            phase();
            rx = {rx[TRIM_BITS-2:0], serial_out_i};
            shift_clk_o <= 1'b1;
            phase();
            shift_clk_o <= 1'b0;
        end
        phase();
        latch_strobe_o <= 1'b1;
        serial_in_o <= ~data[0]; // Data line no longer held, so it moves
        phase();
        latch_strobe_o <= 1'b0;
        phase();
    endtask
endmodule

// ==== tb/lsd_serial_ctrl_test.sv ====
// Self-checking bench of the LED sink driver serial control
`timescale 1ns/100ps
module lsd_serial_ctrl_test;
    import lsd_pkg::*;
    logic                    core_clk, nrst, clk_en, shift_clk, serial_in, latch_strobe, mode_sel;
    logic                    out_disable, over_temp, wr, rd, irq, serial_out, err_n, err_oe;
    logic [CHANNELS-1:0]     out_low, sink_en, v, r, ever;
    logic [1:0]              addr;
    logic [31:0]             wdata, rdata, d;
    logic [TRIM_BITS-1:0]    current_trim, pkt, rx;
    logic [ST_WIDTH-1:0]     m;
    int                      mismatches, total_checks;
    int                      t[CHANNELS];

    lsd_serial_ctrl u_lsd_serial_ctrl (.core_clk_i(core_clk), .nrst_i(nrst), .clk_en_i(clk_en),
        .shift_clk_i(shift_clk), .serial_in_i(serial_in), .latch_strobe_i(latch_strobe),
        .mode_sel_i(mode_sel), .out_disable_i(out_disable), .over_temp_i(over_temp),
        .out_low_i(out_low), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .irq_o(irq), .serial_out_o(serial_out), .sink_en_o(sink_en), .current_trim_o(current_trim),
        .error_out_n_o(err_n), .error_out_n_oe_o(err_oe));
    lsd_host_model u_lsd_host_model (.core_clk_i(core_clk), .serial_out_i(serial_out),
        .shift_clk_o(shift_clk), .serial_in_o(serial_in), .latch_strobe_o(latch_strobe),
        .mode_sel_o(mode_sel));

    // Clock at 100 ns period
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // One compare for all values
    task automatic chk(input string name, input logic [TRIM_BITS-1:0] exp, input logic [TRIM_BITS-1:0] got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    // Bus cycles, entered just after a rising edge
    task automatic bus_wr(input logic [1:0] a, input logic [31:0] dat);
        addr <= a;
        wdata <= dat;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [1:0] a, output logic [31:0] dat);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        @(posedge core_clk);
        dat = rdata;
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog well beyond the roughly 1700 cycles the tests need
    initial
    begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        wrap_up();
    end

    // Main sequence
    initial
    begin
        {nrst, wr, rd, over_temp, out_disable} = '0;
        {addr, wdata, out_low} = '0;
        clk_en = 1'b1;
        void'($urandom(32'h2c24));
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        bus_rd(ADDR_MASK, d);
        chk("mask reset", TRIM_BITS'(MASK_RESET), TRIM_BITS'(d));
        m = ST_WIDTH'($urandom);
        bus_wr(ADDR_MASK, 32'(m));
        bus_rd(ADDR_MASK, d);
        chk("mask", TRIM_BITS'(m), TRIM_BITS'(d));
        // Trim packet with full-scale and zero words at the ends
        pkt = TRIM_BITS'({$urandom, $urandom, $urandom, $urandom});
        pkt[6:0] = 7'h7f;
        pkt[111:105] = 7'h00;
        u_lsd_host_model.send(1'b1, pkt, TRIM_BITS, rx);
        repeat (8) @(posedge core_clk);
        chk("trim", pkt, current_trim);
        bus_rd(ADDR_ONOFF, d);
        chk("on/off untouched", TRIM_BITS'(ONOFF_RESET), TRIM_BITS'(d));
        // On/off packet, watching when each channel comes on
        v = CHANNELS'($urandom) | 16'h0001;
        foreach (t[n]) t[n] = -1;
        fork
            u_lsd_host_model.send(1'b0, TRIM_BITS'(v), ONOFF_BITS, rx);
            for (int c = 0; c < 200; c++)
            begin
                @(posedge core_clk);
                foreach (t[n]) if (sink_en[n] === 1'b1 && t[n] < 0) t[n] = c;
            end
        join
        foreach (t[n]) if (v[n]) chk("stagger", TRIM_BITS'(n), TRIM_BITS'(t[n] - t[0]));
        chk("sink", TRIM_BITS'(v), TRIM_BITS'(sink_en));
        bus_rd(ADDR_ONOFF, d);
        chk("on/off reg", TRIM_BITS'(v), TRIM_BITS'(d));
        // Blanking, then a short unblank shorter than the stagger
        out_disable <= 1'b1;
        repeat (30) @(posedge core_clk);
        chk("blanked", '0, TRIM_BITS'(sink_en));
        ever = '0;
        out_disable <= 1'b0;
        for (int c = 0; c < 50; c++)
        begin
            @(posedge core_clk);
            if (c == 6)
                out_disable <= 1'b1;
            ever |= sink_en;
        end
        chk("lit anyway", TRIM_BITS'(v), TRIM_BITS'(ever));
        // Open channels, first and last among them, read back over the link
        r = CHANNELS'($urandom) | 16'h8001;
        out_low <= r;
        out_disable <= 1'b0;
        u_lsd_host_model.send(1'b0, TRIM_BITS'(16'hffff), ONOFF_BITS, rx);
        repeat (30) @(posedge core_clk);
        u_lsd_host_model.send(1'b0, TRIM_BITS'(16'hffff), ONOFF_BITS, rx);
        u_lsd_host_model.send(1'b0, TRIM_BITS'(16'hffff), ONOFF_BITS, rx);
        chk("open readback", TRIM_BITS'(r), TRIM_BITS'(rx[15:0]));
        bus_rd(ADDR_OPEN, d);
        chk("open reg", TRIM_BITS'(r), TRIM_BITS'(d));
        chk("error open", TRIM_BITS'(1'b1), TRIM_BITS'(err_oe));
        out_disable <= 1'b1;
        repeat (10) @(posedge core_clk);
        chk("error masked", '0, TRIM_BITS'(err_oe));
        // Thermal event raises the unmasked interrupt, clear by writing one
        bus_wr(ADDR_MASK, 32'h1 << ST_THERMAL);
        over_temp <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk("error hot", TRIM_BITS'(1'b1), TRIM_BITS'(err_oe));
        chk("irq set", TRIM_BITS'(1'b1), TRIM_BITS'(irq));
        bus_rd(ADDR_STATUS, d);
        chk("status hot", TRIM_BITS'(1'b1), TRIM_BITS'(d[ST_THERMAL]));
        over_temp <= 1'b0;
        repeat (8) @(posedge core_clk);
        bus_wr(ADDR_STATUS, 32'h7);
        @(posedge core_clk);
        chk("irq clear", '0, TRIM_BITS'(irq));
        wrap_up();
    end
endmodule

bind lsd_serial_ctrl lsd_serial_ctrl_asserts #(.CH(CH), .TW(TW)) u_lsd_serial_ctrl_asserts (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i), .mode_sel_i(mode_sel_i),
    .out_disable_i(out_disable_i), .over_temp_i(over_temp_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .sink_en_o(sink_en_o),
    .current_trim_o(current_trim_o), .error_out_n_o(error_out_n_o), .error_out_n_oe_o(error_out_n_oe_o));
